// *** irq_accept_address_map.sv ***
// Interrupt acceptance, stack selection and address decode with AXI4-Lite
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module irq_accept_address_map #(
    parameter int ROM_SIZE = irq_accept_pkg::ROM_BYTES,
    parameter int RAM_SIZE = irq_accept_pkg::RAM_BYTES
) (
    input  wire logic                               ref_clk,
    input  wire logic                               rst_b,
    input  wire logic [7:0]                         s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [7:0]                         s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    input  wire logic                               irqReq,
    input  wire logic [irq_accept_pkg::LEVEL_W-1:0] irqPriority,
    input  wire logic                               trapValid,
    input  wire logic [irq_accept_pkg::TRAP_W-1:0]  trapNumber,
    input  wire logic [irq_accept_pkg::ADDR_W-1:0]  memAddr,
    output logic                                    irqAck,
    output logic                                    trapAck,
    output logic                                    stackSelUser,
    output logic [irq_accept_pkg::SP_W-1:0]         activeSp,
    output logic                                    saveValid,
    output logic [irq_accept_pkg::SP_W-1:0]         saveAddr,
    output logic                                    stackFault,
    output logic                                    selRegArea,
    output logic                                    selRam,
    output logic                                    selRom,
    output logic                                    selVector,
    output logic                                    selReserved
);
    import irq_accept_pkg::*;

    localparam logic [ADDR_W-1:0] ROM_LO =
        ADDR_W'(int'(ROM_HI) + 1 - ROM_SIZE);
    localparam logic [ADDR_W-1:0] RAM_HI =
        ADDR_W'(int'(RAM_LO) + RAM_SIZE - 1);

    typedef struct packed {
        logic                irqEn;
        logic                stkSel;
        logic [LEVEL_W-1:0]  level;
        logic [SP_W-1:0]     interrupt_stack_pointer;
        logic [SP_W-1:0]     user_stack_pointer;
        logic                ack;
        logic                saveValid;
        logic [SP_W-1:0]     saveAddr;
        logic                stackFault;
        logic [7:0]          acceptCount;
        logic [LEVEL_W-1:0]  lastPri;
        logic                awHave;
        logic [7:0]          awAddr;
        logic                wHave;
        logic [31:0]         wData;
        logic [3:0]          wStrb;
        logic                bValid;
        logic [1:0]          bResp;
        logic                rValid;
        logic [31:0]         rData;
        logic [1:0]          rResp;
    } state_t;

    state_t st;
    state_t next_st;

    logic                hwAccept;
    logic                trapTake;
    logic                doWrite;
    logic [SP_W-1:0]     pushSp;
    logic [SP_W-1:0]     pushAddr;
    logic                pushUser;
    logic [31:0]         flagWord;
    logic [31:0]         rdWord;
    logic                rdHit;

    // Request gating: enable flag and strict priority, same cycle
    assign hwAccept = irqReq && st.irqEn &&
                      (irqPriority > st.level); // RULE_01 RULE_06 RULE_15
    // Hardware wins a tie; the core retries its trap next cycle
    assign trapTake = trapValid && !hwAccept;
    assign trapAck  = trapTake;

    // Stack in use by the push; hardware entry always uses interrupt stack
    assign pushUser = hwAccept ? 1'b0 : st.stkSel; // RULE_03
    assign pushSp   = pushUser ? st.user_stack_pointer : st.interrupt_stack_pointer; // RULE_03
    assign pushAddr = pushSp - CTX_BYTES; // RULE_12

    // Reserved bit reads 0, which is one legal undefined value
    assign flagWord = {24'h000000, 1'b0, st.level, 1'b0, 1'b0,
                       st.stkSel, st.irqEn}; // RULE_05 RULE_07

    // Write proceeds once both address and data are held
    assign doWrite  = st.awHave && st.wHave && !st.bValid;

    // Read mux and decode of the offered read address
    always_comb begin
        rdHit  = 1'b1;
        rdWord = 32'h00000000;
        unique case (s_axi_araddr)
            OFS_FLAG:   rdWord = flagWord;
            OFS_ISP:    rdWord = {16'h0000, st.interrupt_stack_pointer};
            OFS_USP:    rdWord = {16'h0000, st.user_stack_pointer};
            OFS_STATUS: rdWord = {16'h0000, st.acceptCount,
                                  1'b0, st.lastPri, 3'h0, st.stackFault};
            default:    rdHit  = 1'b0;
        endcase
    end

    // Next-state logic: bus first, hardware effects last so they win
    always_comb begin
        next_st           = st;
        next_st.ack       = 1'b0;
        next_st.saveValid = 1'b0;
        // Address and data channels captured independently
        if (s_axi_awvalid && !st.awHave) begin
            next_st.awHave = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wHave) begin
            next_st.wHave = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            next_st.awHave = 1'b0;
            next_st.wHave  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = RESP_OKAY;
            unique case (st.awAddr)
                OFS_FLAG: begin
                    if (st.wStrb[0]) begin
                        next_st.irqEn  = st.wData[POS_EN];
                        next_st.stkSel = st.wData[POS_SEL];
                        next_st.level  =
                            st.wData[POS_LEVEL +: LEVEL_W]; // RULE_05
                    end
                end
                OFS_ISP: begin
                    if (st.wStrb[0]) next_st.interrupt_stack_pointer[7:0]  = st.wData[7:0];
                    if (st.wStrb[1]) next_st.interrupt_stack_pointer[15:8] = st.wData[15:8];
                end
                OFS_USP: begin
                    if (st.wStrb[0]) next_st.user_stack_pointer[7:0]  = st.wData[7:0];
                    if (st.wStrb[1]) next_st.user_stack_pointer[15:8] = st.wData[15:8];
                end
                // Writing the status word with bit 0 set clears the sticky fault
                OFS_STATUS: begin
                    if (st.wStrb[0] && st.wData[0]) begin
                        next_st.stackFault = 1'b0;
                    end
                end
                default: next_st.bResp = RESP_SLVERR;
            endcase
        end
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end
        // Read: one outstanding, answered the cycle after arvalid
        if (s_axi_arvalid && !st.rValid) begin
            next_st.rValid = 1'b1;
            next_st.rData  = rdWord;
            next_st.rResp  = rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end
        // Acceptance effects override any same-cycle software write
        if (hwAccept || trapTake) begin
            next_st.irqEn     = 1'b0; // RULE_02
            next_st.saveValid = 1'b1; // RULE_12
            next_st.saveAddr  = pushAddr; // RULE_12
            if (pushUser) next_st.user_stack_pointer = pushAddr;
            else          next_st.interrupt_stack_pointer = pushAddr;
            // Push landing outside RAM is flagged, set beats clear
            if (pushAddr < RAM_LO[SP_W-1:0] ||
                pushAddr > RAM_HI[SP_W-1:0]) begin
                next_st.stackFault = 1'b1; // RULE_12
            end
        end
        if (hwAccept) begin
            next_st.ack         = 1'b1;
            next_st.stkSel      = 1'b0; // RULE_04
            next_st.level       = irqPriority;
            next_st.lastPri     = irqPriority;
            next_st.acceptCount = st.acceptCount + 8'h01;
        end
        if (trapTake && trapNumber <= TRAP_LOW_MAX) begin
            next_st.stkSel = 1'b0; // RULE_04
        end
    end

    // State register with synchronous active-low reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st       <= '0;
            st.level <= RST_LEVEL;
            st.interrupt_stack_pointer   <= RST_SP;
            st.user_stack_pointer   <= RST_SP;
        end else begin
            st <= next_st;
        end
    end

    // Bus outputs; ready is withheld while a channel is already held
    assign s_axi_awready = !st.awHave;
    assign s_axi_wready  = !st.wHave;
    assign s_axi_bvalid  = st.bValid;
    assign s_axi_bresp   = st.bResp;
    assign s_axi_arready = !st.rValid;
    assign s_axi_rvalid  = st.rValid;
    assign s_axi_rdata   = st.rData;
    assign s_axi_rresp   = st.rResp;

    // Core-side outputs
    assign irqAck       = st.ack;
    assign stackSelUser = st.stkSel;
    assign activeSp     = st.stkSel ? st.user_stack_pointer : st.interrupt_stack_pointer; // RULE_03
    assign saveValid    = st.saveValid;
    assign saveAddr     = st.saveAddr;
    assign stackFault   = st.stackFault;

    // Flat decode of the 1-Mbyte space; vector table lies inside ROM
    assign selRegArea  = memAddr <= AREA_HI; // RULE_13
    assign selRam      = memAddr >= RAM_LO && memAddr <= RAM_HI; // RULE_11
    assign selRom      = memAddr >= ROM_LO && memAddr <= ROM_HI; // RULE_09
    assign selVector   = memAddr >= VEC_LO && memAddr <= ROM_HI; // RULE_10
    // Everything else, up to the top of the space, is a hole
    assign selReserved = !(selRegArea || selRam || selRom); // RULE_08

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence seqGoodReq;
        irqReq && st.irqEn && (irqPriority > st.level);
    endsequence

    sequence seqAckSave;
        st.ack && st.saveValid && (st.saveAddr == st.interrupt_stack_pointer);
    endsequence

    AST_MASK_BLOCKS: assert property ( // RULE_01
        (irqReq && !st.irqEn) |=> !irqAck)
        else $error("Request acknowledged while enable flag was low");
    AST_ACK_CLEARS_EN: assert property ( // RULE_02
        irqAck |-> !st.irqEn ##1 !irqAck || !$past(st.irqEn))
        else $error("Enable flag not cleared by acknowledge");
    AST_HW_CLEARS_SEL: assert property ( // RULE_04
        irqAck |-> !stackSelUser)
        else $error("Stack select not cleared by hardware acknowledge");
    AST_TRAP_CLEARS_SEL: assert property ( // RULE_04
        (trapAck && trapNumber <= TRAP_LOW_MAX) |=> !stackSelUser)
        else $error("Low trap did not select interrupt stack");
    AST_TRAP_KEEPS_SEL: assert property ( // RULE_04
        (trapAck && trapNumber > TRAP_LOW_MAX && stackSelUser) |=>
        stackSelUser)
        else $error("High trap changed stack select");
    AST_PRIO_GATE: assert property ( // RULE_06
        (irqReq && st.irqEn && irqPriority <= st.level) |=> !irqAck)
        else $error("Request at or below level was acknowledged");
    AST_ACCEPT: assert property ( // RULE_15
        seqGoodReq |=> irqAck && st.level == $past(irqPriority))
        else $error("Qualified request not acknowledged next cycle");
    AST_SAVE_ISP: assert property ( // RULE_12
        irqAck |-> seqAckSave)
        else $error("Context save not on interrupt stack");
    AST_REG_AREA: assert property ( // RULE_13
        (memAddr <= 20'h002FF) |-> selRegArea && !selRam && !selRom)
        else $error("Register area decode wrong");
    AST_RAM_DEC: assert property ( // RULE_11
        (memAddr == 20'h00400) |-> selRam && !selReserved)
        else $error("RAM base not decoded");
    AST_VEC_DEC: assert property ( // RULE_10
        (memAddr >= 20'h0FFDC && memAddr <= 20'h0FFFF) |->
        selVector && selRom)
        else $error("Vector table decode wrong");
    AST_ONE_REGION: assert property ( // RULE_08
        $onehot({selRegArea, selRam, selRom, selReserved}))
        else $error("Address decoded into more than one region");
    AST_BRESP_HOLD: assert property (
        (s_axi_bvalid && !s_axi_bready) |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before bready");
    // Trap entry masks further requests just like hardware entry
    AST_TRAP_CLEARS_EN: assert property ( // RULE_02
        trapAck |=> !st.irqEn)
        else $error("Enable flag not cleared by trap");
    // Each hardware entry moves the interrupt stack down by one frame
    AST_PUSH_STEP: assert property ( // RULE_12
        irqAck |-> saveAddr == $past(st.interrupt_stack_pointer) - CTX_BYTES)
        else $error("Context push did not step the interrupt stack");
    // A push outside RAM must leave the sticky fault standing
    AST_FAULT_SET: assert property ( // RULE_12
        (saveValid && (saveAddr < RAM_LO[SP_W-1:0] ||
                       saveAddr > RAM_HI[SP_W-1:0])) |-> stackFault)
        else $error("Push outside RAM not flagged");
endmodule

// *** irq_accept_pkg.sv ***
// Constants, register map and decode layout for the interrupt acceptor
// Contract
// RULE_01: Maskable requests are blocked while the enable flag is 0.
// RULE_02: Any acknowledged interrupt clears the enable flag to 0.
// RULE_03: Stack select 0 picks interrupt stack, 1 picks user stack.
// RULE_04: Hardware acknowledge or trap number 0 to 31 clears stack select.
// RULE_05: Priority level is a 3-bit field, levels 0 through 7.
// RULE_06: A request is enabled only if its priority exceeds the level.
// RULE_07: Reserved flag bit reads undefined; software writes it as 0.
// RULE_08: One flat 1-Mbyte space from 00000h to FFFFFh is decoded.
// RULE_09: Program ROM ends at 0FFFFh and grows downward by its size.
// RULE_10: Vector table occupies 0FFDCh to 0FFFFh at the top of ROM.
// RULE_11: RAM starts at 00400h and grows upward by its size.
// RULE_12: Acknowledge saves context onto a stack held in RAM.
// RULE_13: Peripheral register area spans 00000h through 002FFh.
// RULE_14: Software must not touch unassigned peripheral area locations.
// RULE_15: Accept only if enable is 1 and priority beats level same cycle.
package irq_accept_pkg;
    localparam int          ADDR_W        = 20;
    localparam int          LEVEL_W       = 3;
    localparam int          SP_W          = 16;
    localparam int          TRAP_W        = 6;
    // Register byte offsets
    localparam logic [7:0]  OFS_FLAG      = 8'h00;
    localparam logic [7:0]  OFS_ISP       = 8'h04;
    localparam logic [7:0]  OFS_USP       = 8'h08;
    localparam logic [7:0]  OFS_STATUS    = 8'h0C;
    // Flag register field positions
    localparam int          POS_EN        = 0;
    localparam int          POS_SEL       = 1;
    localparam int          POS_RSV       = 3;
    localparam int          POS_LEVEL     = 4;
    // Reset values
    localparam logic [SP_W-1:0]    RST_SP    = 16'h0000;
    localparam logic [LEVEL_W-1:0] RST_LEVEL = 3'h0;
    // Address map
    localparam logic [ADDR_W-1:0] AREA_LO  = 20'h00000;
    localparam logic [ADDR_W-1:0] AREA_HI  = 20'h002FF;
    localparam logic [ADDR_W-1:0] RAM_LO   = 20'h00400;
    localparam logic [ADDR_W-1:0] ROM_HI   = 20'h0FFFF;
    localparam logic [ADDR_W-1:0] VEC_LO   = 20'h0FFDC;
    localparam logic [ADDR_W-1:0] SPACE_HI = 20'hFFFFF;
    localparam int          ROM_BYTES     = 49152;
    localparam int          RAM_BYTES     = 2560;
    // Trap numbers up to this one switch to the interrupt stack
    localparam logic [TRAP_W-1:0] TRAP_LOW_MAX = 6'h1F;
    // Bytes pushed per context save
    localparam logic [SP_W-1:0] CTX_BYTES = 16'h0004;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// *** irq_source_model.sv ***
// Peripheral model that raises one maskable interrupt request
`timescale 1ns/1ps
module irq_source_model (
    input  wire logic                               ref_clk,
    input  wire logic                               rst_b,
    input  wire logic                               want,
    input  wire logic [irq_accept_pkg::LEVEL_W-1:0] wantPri,
    input  wire logic                               irqAck,
    output logic                                    irqReq,
    output logic [irq_accept_pkg::LEVEL_W-1:0]      irqPriority
);
    import irq_accept_pkg::*;
    // Request stays up while wanted until acknowledged; an acknowledge drops it for one cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irqReq      <= 1'h0;
            irqPriority <= 3'h0;
        end else if (irqAck || !want) begin
            irqReq      <= 1'h0;
            irqPriority <= ~irqPriority; // Level inverts each idle cycle, so the stale level recurs every other cycle
        end else begin
            irqReq      <= 1'h1;
            irqPriority <= wantPri;
        end
    end
endmodule

// *** testbench.sv ***
// Self-checking bench for interrupt acceptance and address decode
`timescale 1ns/1ps
module testbench;
    import irq_accept_pkg::*;
    logic        ref_clk = 1'h0, rst_b = 1'h0;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic        awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
    logic        arValid = 1'h0, rReady = 1'h0, want = 1'h0;
    logic [2:0]  wantPri = 3'h0, irqPriority;
    logic        trapValid = 1'h0;
    logic [5:0]  trapNumber = 6'h00;
    logic [19:0] memAddr = 20'h00000;
    logic        awReady, wReady, bValid, arReady, rValid, irqReq;
    logic        irqAck, trapAck, stackSelUser, saveValid, stackFault;
    logic        selRegArea, selRam, selRom, selVector, selReserved;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    logic [15:0] activeSp, saveAddr;
    logic [4:0]  hit;
    int          err_count = 0;
    int          n_compared = 0;

    always #12.5 ref_clk = ~ref_clk;

    // Region selects gathered as {regArea, ram, rom, vector, reserved}
    assign hit = {selRegArea, selRam, selRom, selVector, selReserved};

    irq_accept_address_map DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .irqReq(irqReq), .irqPriority(irqPriority),
        .trapValid(trapValid), .trapNumber(trapNumber), .memAddr(memAddr),
        .irqAck(irqAck), .trapAck(trapAck), .stackSelUser(stackSelUser),
        .activeSp(activeSp), .saveValid(saveValid), .saveAddr(saveAddr),
        .stackFault(stackFault), .selRegArea(selRegArea), .selRam(selRam),
        .selRom(selRom), .selVector(selVector), .selReserved(selReserved)
    );

    irq_source_model peripheral (
        .ref_clk(ref_clk), .rst_b(rst_b), .want(want), .wantPri(wantPri),
        .irqAck(irqAck), .irqReq(irqReq), .irqPriority(irqPriority)
    );

    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Handshakes sampled mid-cycle so the edge that takes them is known
    // bready comes one cycle after bvalid so the response hold is seen
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er);
        logic awDone, wDone, bSeen;
        logic bDone = 1'h0;
        @(posedge ref_clk);
        awAddr  <= a;
        wData   <= d;
        awValid <= 1'h1;
        wValid  <= 1'h1;
        while (!bDone) begin
            @(negedge ref_clk);
            awDone = awValid && awReady;
            wDone  = wValid && wReady;
            bSeen  = bValid;
            bDone  = bValid && bReady;
            if (bDone) check("bresp", bResp, er);
            @(posedge ref_clk);
            if (awDone) awValid <= 1'h0;
            if (wDone) wValid <= 1'h0;
            if (bSeen && !bDone) bReady <= 1'h1;
        end
        bReady <= 1'h0;
    endtask

    task automatic readChk(input string nm, input logic [7:0] a,
                           input logic [31:0] exp, input logic [1:0] er);
        logic arDone;
        logic rDone = 1'h0;
        @(posedge ref_clk);
        arAddr  <= a;
        arValid <= 1'h1;
        rReady  <= 1'h1;
        while (!rDone) begin
            @(negedge ref_clk);
            arDone = arValid && arReady;
            rDone  = rValid;
            if (rDone) check(nm, rData, exp);
            if (rDone) check("rresp", rResp, er);
            @(posedge ref_clk);
            if (arDone) arValid <= 1'h0;
        end
        rReady <= 1'h0;
    endtask

    // Raise a request for six cycles and note whether it was taken
    task automatic tryIrq(input logic [2:0] p, input logic expAck,
                          input logic [15:0] expSave);
        logic got = 1'h0;
        @(posedge ref_clk);
        want    <= 1'h1;
        wantPri <= p;
        repeat (6) begin
            @(negedge ref_clk);
            if (irqAck === 1'h1 && !got) begin
                got = 1'h1;
                check("saveValid", saveValid, 1'h1);
                check("saveAddr", saveAddr, expSave);
                check("stackSelUser", stackSelUser, 1'h0);
            end
        end
        @(posedge ref_clk);
        want <= 1'h0;
        check("irqAck", got, expAck);
    endtask

    task automatic doTrap(input logic [5:0] n, input logic expSel,
                          input logic [15:0] expSave);
        @(posedge ref_clk);
        trapValid  <= 1'h1;
        trapNumber <= n;
        @(negedge ref_clk);
        check("trapAck", trapAck, 1'h1);
        @(posedge ref_clk);
        trapValid <= 1'h0;
        @(negedge ref_clk);
        check("saveAddr", saveAddr, expSave);
        check("stackSelUser", stackSelUser, expSel);
    endtask

    // Region edges: {regArea, ram, rom, vector, reserved}
    task automatic decodeMap();
        logic [19:0] ad [14] = '{20'h00000, 20'h002FF, 20'h00300,
            20'h003FF, 20'h00400, 20'h00DFF, 20'h00E00, 20'h03FFF,
            20'h04000, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF, 20'h10000,
            20'hFFFFF};
        logic [4:0] sl [14] = '{5'h10, 5'h10, 5'h01, 5'h01, 5'h08,
            5'h08, 5'h01, 5'h01, 5'h04, 5'h04, 5'h06, 5'h06, 5'h01,
            5'h01};
        // Decode probes only; no register location is ever accessed
        foreach (ad[i]) begin
            @(posedge ref_clk);
            memAddr <= ad[i];
            @(negedge ref_clk);
            check("regions", hit[4:2], sl[i][4:2]);
            check("vecHole", hit[1:0], sl[i][1:0]);
        end
    endtask

    // Reserved flag bit 3 is always written as 0
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        readChk("flag", OFS_FLAG, 32'h0, RESP_OKAY);
        decodeMap();
        axiWrite(OFS_ISP, 32'h0C00, RESP_OKAY);
        axiWrite(OFS_USP, 32'h0D00, RESP_OKAY);
        axiWrite(OFS_FLAG, 32'h32, RESP_OKAY);
        tryIrq(3'h7, 1'h0, 16'h0);
        axiWrite(OFS_FLAG, 32'h33, RESP_OKAY);
        check("activeSp", activeSp, 16'h0D00);
        tryIrq(3'h3, 1'h0, 16'h0);
        tryIrq(3'h4, 1'h1, 16'h0BFC);
        readChk("flag", OFS_FLAG, 32'h40, RESP_OKAY);
        readChk("status", OFS_STATUS, 32'h140, RESP_OKAY);
        check("activeSp", activeSp, 16'h0BFC);
        axiWrite(OFS_FLAG, 32'h73, RESP_OKAY);
        tryIrq(3'h7, 1'h0, 16'h0);
        axiWrite(OFS_FLAG, 32'h03, RESP_OKAY);
        doTrap(6'h20, 1'h1, 16'h0CFC);
        readChk("flag", OFS_FLAG, 32'h02, RESP_OKAY);
        axiWrite(OFS_FLAG, 32'h03, RESP_OKAY);
        doTrap(6'h1F, 1'h0, 16'h0CF8);
        readChk("flag", OFS_FLAG, 32'h00, RESP_OKAY);
        readChk("unmapped", 8'h10, 32'h0, RESP_SLVERR);
        // Push from the RAM floor lands below RAM and must be flagged
        axiWrite(OFS_ISP, 32'h0400, RESP_OKAY);
        axiWrite(OFS_FLAG, 32'h01, RESP_OKAY);
        tryIrq(3'h1, 1'h1, 16'h03FC);
        check("stackFault", stackFault, 1'h1);
        readChk("status", OFS_STATUS, 32'h211, RESP_OKAY);
        axiWrite(OFS_STATUS, 32'h01, RESP_OKAY);
        check("stackFault", stackFault, 1'h0);
        axiWrite(8'h10, 32'h0, RESP_SLVERR);
        // Mid-run reset brings counters and stack pointers back to idle
        rst_b <= 1'h0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'h1;
        readChk("status", OFS_STATUS, 32'h0, RESP_OKAY);
        readChk("isp", OFS_ISP, 32'h0, RESP_OKAY);
        results();
    end

    // Whole run needs under two hundred cycles; cut a hang well beyond
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        results();
    end
endmodule
